// ===== include/irs_pkg.sv
/*
 * irs_pkg: constants and carrier types for the internal RAM error status block.
 * assumes: one 40 MHz core clock; every event input comes from logic on that clock.
 */
package irs_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int FLAG_W = 15;
	localparam int CNT_W  = 8;
	localparam int TMR_W  = 26;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CHECK_DISABLE = 12'h1c8;
	localparam logic [ADDR_W-1:0] OFS_ERROR_FLAGS   = 12'h1cc;
	localparam logic [ADDR_W-1:0] OFS_ERROR_MASKS   = 12'h1d0;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int DIS_ONE_BIT = 0;
	localparam int DIS_TWO_BIT = 1;
	localparam int DIS_W       = 2;

	localparam int FLG_CPL_FIFO_OVF     = 0;
	localparam int FLG_EGR_PKT_SBE_OVF  = 1;
	localparam int FLG_EGR_LINK_SBE_OVF = 2;
	localparam int FLG_EGR_PKT_DBE      = 3;
	localparam int FLG_EGR_LINK_DBE     = 4;
	localparam int FLG_ING_PKT_SBE      = 5;
	localparam int FLG_EGR_ALLOC_SBE    = 6;
	localparam int FLG_EGR_ALLOC_DBE    = 7;
	localparam int FLG_ING_PKT_DBE      = 8;
	localparam int FLG_ING_LINK_SBE     = 9;
	localparam int FLG_ING_LINK_DBE     = 10;
	localparam int FLG_CREDIT_TIMEOUT   = 11;
	localparam int FLG_CREDIT_UNDERRUN  = 12;
	localparam int FLG_ING_ALLOC_SBE    = 13;
	localparam int FLG_ING_ALLOC_DBE    = 14;

	localparam logic [DIS_W-1:0]  DISABLE_RESET = 2'h0;
	localparam logic [FLAG_W-1:0] FLAGS_RESET   = 15'h0000;
	localparam logic [FLAG_W-1:0] MASKS_RESET   = 15'h7fff;

	// ----------------------------------------
	// soft error counter thresholds
	// ----------------------------------------
	localparam int PKT_LINK_SBE_LIMIT = 256;
	localparam int ALLOC_SBE_LIMIT    = 8;

	// ----------------------------------------
	// credit update timeout
	// ----------------------------------------
	localparam longint CLK_HZ             = 40000000;
	localparam longint CREDIT_TMO_SHORT_MS = 512;
	localparam longint CREDIT_TMO_LONG_MS  = 1000;
	localparam longint MS_PER_S            = 1000;
	localparam int CREDIT_TMO_SHORT_CYC = int'(CREDIT_TMO_SHORT_MS * CLK_HZ / MS_PER_S);
	localparam int CREDIT_TMO_LONG_CYC  = int'(CREDIT_TMO_LONG_MS * CLK_HZ / MS_PER_S);

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} irs_reg_req_t;

	typedef struct packed {
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
	} irs_reg_rsp_t;

	typedef struct packed {
		logic ing_cpl_fifo_ovf;
		logic egr_cpl_fifo_ovf;
		logic egr_packet_ram_sbe;
		logic egr_packet_ram_dbe;
		logic egr_link_list_ram_sbe;
		logic egr_link_list_ram_dbe;
		logic ing_packet_ram_sbe;
		logic ing_packet_ram_dbe;
		logic ing_link_list_ram_sbe;
		logic ing_link_list_ram_dbe;
		logic egr_memory_allocation_unit_sbe;
		logic egr_memory_allocation_unit_dbe;
		logic ing_memory_allocation_unit_sbe;
		logic ing_memory_allocation_unit_dbe;
		logic credit_update;
		logic credit_pending;
		logic ingress_credit_handler_underrun;
	} irs_events_t;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic             reached;
	} irs_cnt_state_t;

	typedef struct packed {
		logic [TMR_W-1:0] count;
		logic             fired;
	} irs_tmr_state_t;

endpackage

// ===== src/irs_sbe_counter.sv
/*
 * irs_sbe_counter: saturating soft error counter with a threshold pulse.
 * assumes: event_in is a one-cycle pulse on clock_in; LIMIT fits CNT_W plus one bit.
 */
`timescale 1ns/1ps
module irs_sbe_counter #(
	parameter int LIMIT = irs_pkg::PKT_LINK_SBE_LIMIT
) (
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic event_in,
	output logic      reached_out
);

	localparam logic [irs_pkg::CNT_W-1:0] LAST = irs_pkg::CNT_W'(LIMIT - 1);
	localparam logic [irs_pkg::CNT_W-1:0] ONE  = irs_pkg::CNT_W'(1);

	irs_pkg::irs_cnt_state_t st_r;
	irs_pkg::irs_cnt_state_t st_nxt;

	// ----------------------------------------
	// count
	// ----------------------------------------
	// saturates at LIMIT-1 so every later error re-raises the flag after software clears it
	always_comb begin
		st_nxt         = st_r;
		st_nxt.reached = 1'b0;
		if (event_in) begin
			if (st_r.count == LAST) begin
				st_nxt.reached = 1'b1;
			end else begin
				st_nxt.count = st_r.count + ONE;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reached_out = st_r.reached;

endmodule

// ===== src/irs_credit_timer.sv
/*
 * irs_credit_timer: watches for a missing credit update while credit is pending.
 * assumes: update and pending come from the credit logic on clock_in.
 */
`timescale 1ns/1ps
module irs_credit_timer #(
	parameter int SHORT_CYC = irs_pkg::CREDIT_TMO_SHORT_CYC,
	parameter int LONG_CYC  = irs_pkg::CREDIT_TMO_LONG_CYC
) (
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic enable_in,
	input  wire logic long_sel_in,
	input  wire logic update_in,
	input  wire logic pending_in,
	output logic      timeout_out
);

	localparam logic [irs_pkg::TMR_W-1:0] SHORT_LAST = irs_pkg::TMR_W'(SHORT_CYC - 1);
	localparam logic [irs_pkg::TMR_W-1:0] LONG_LAST  = irs_pkg::TMR_W'(LONG_CYC - 1);
	localparam logic [irs_pkg::TMR_W-1:0] ONE        = irs_pkg::TMR_W'(1);

	irs_pkg::irs_tmr_state_t st_r;
	irs_pkg::irs_tmr_state_t st_nxt;
	logic [irs_pkg::TMR_W-1:0] last;

	// ----------------------------------------
	// timer
	// ----------------------------------------
	// restarts after firing, so a stall that persists reports once per period
	always_comb begin
		last         = long_sel_in ? LONG_LAST : SHORT_LAST;
		st_nxt       = st_r;
		st_nxt.fired = 1'b0;
		if (!enable_in || !pending_in || update_in) begin
			st_nxt.count = '0;
		end else if (st_r.count >= last) begin
			st_nxt.count = '0;
			st_nxt.fired = 1'b1;
		end else begin
			st_nxt.count = st_r.count + ONE;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign timeout_out = st_r.fired;

endmodule

// ===== src/irs_error_status.sv
/*
 * irs_error_status: check-disable, sticky error flags and masks for internal RAMs,
 * with a reporting interrupt for unmasked flags.
 * assumes: register port and event inputs are on clock_in; rst_in is synchronous.
 */
`timescale 1ns/1ps

// Operation
// - bit 0 of check disable stops single-bit soft error checking; resets to zero.
// - bit 1 of check disable stops double-bit soft error checking; resets to zero.
// - any flag may raise an interrupt, only while its reporting is enabled.
// - flag 0 sets on ingress or egress completion FIFO overflow.
// - egress packet RAM single-bit errors counted in 8 bits; flag 1 at 256.
// - egress link-list RAM single-bit errors counted in 8 bits; flag 2 at 256.
// - flag 3 sets on egress packet RAM double-bit error.
// - flag 4 sets on egress link-list RAM double-bit error.
// - flag 5 sets on ingress packet RAM single-bit error.
// - flag 6 sets when egress allocation unit single-bit count reaches eight.
// - flag 7 sets on egress allocation unit double-bit error.
// - flag 8 sets on ingress packet RAM double-bit error.
// - flag 9 sets on ingress link-list RAM single-bit error.
// - flag 10 sets on ingress link-list RAM double-bit error.
// - flag 11 sets on credit update timeout of 512 ms or 1 s; off by default.
// - flag 12 sets on ingress credit handler underrun.
// - flag 13 sets when ingress allocation unit single-bit count reaches eight.
// - flag 14 sets on ingress allocation unit double-bit error.
// - each flag has a mask bit; set (reset value) suppresses its interrupt, clear allows it.
module irs_error_status #(
	parameter int CREDIT_SHORT_CYC = irs_pkg::CREDIT_TMO_SHORT_CYC,
	parameter int CREDIT_LONG_CYC  = irs_pkg::CREDIT_TMO_LONG_CYC
) (
	input  wire logic                  clock_in,
	input  wire logic                  rst_in,
	input  wire irs_pkg::irs_reg_req_t reg_req_in,
	output irs_pkg::irs_reg_rsp_t      reg_rsp_out,
	input  wire irs_pkg::irs_events_t  events_in,
	input  wire logic                  credit_timeout_en_in,
	input  wire logic                  credit_timeout_long_in,
	output logic                       one_bit_check_en_out,
	output logic                       two_bit_check_en_out,
	output logic                       err_irq_out,
	output logic                       err_msg_req_out
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [irs_pkg::DIS_W-1:0]  check_disable;
		logic [irs_pkg::FLAG_W-1:0] flags;
		logic [irs_pkg::FLAG_W-1:0] masks;
		irs_pkg::irs_reg_rsp_t      rsp;
		logic                       one_bit_en;
		logic                       two_bit_en;
		logic                       irq;
		logic                       msg_req;
	} irs_main_state_t;

	irs_main_state_t st_r;
	irs_main_state_t st_nxt;

	logic                       one_bit_ok;
	logic                       two_bit_ok;
	logic                       egr_pkt_ovf;
	logic                       egr_link_ovf;
	logic                       egr_alloc_ovf;
	logic                       ing_alloc_ovf;
	logic                       credit_tmo;
	logic [irs_pkg::FLAG_W-1:0] ev;
	logic [irs_pkg::FLAG_W-1:0] clr;
	logic [irs_pkg::FLAG_W-1:0] fresh;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input irs_pkg::irs_reg_req_t req,
			input logic [irs_pkg::ADDR_W-1:0] ofs);
		hit = (req.addr == ofs);
	endfunction

	function automatic logic [irs_pkg::DATA_W-1:0] widen(
			input logic [irs_pkg::FLAG_W-1:0] v);
		widen = {{(irs_pkg::DATA_W - irs_pkg::FLAG_W){1'b0}}, v};
	endfunction

	// ----------------------------------------
	// check gating
	// ----------------------------------------
	// checking is gated at the event inputs as well as signalled out, so a
	// checker that lags the enable by a cycle cannot leak a flag
	assign one_bit_ok = ~st_r.check_disable[irs_pkg::DIS_ONE_BIT];
	assign two_bit_ok = ~st_r.check_disable[irs_pkg::DIS_TWO_BIT];

	// ----------------------------------------
	// counters and timer
	// ----------------------------------------
	irs_sbe_counter #(
		.LIMIT(irs_pkg::PKT_LINK_SBE_LIMIT)
	) u_egr_pkt_cnt (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.event_in   (events_in.egr_packet_ram_sbe & one_bit_ok),
		.reached_out(egr_pkt_ovf)
	);

	irs_sbe_counter #(
		.LIMIT(irs_pkg::PKT_LINK_SBE_LIMIT)
	) u_egr_link_cnt (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.event_in   (events_in.egr_link_list_ram_sbe & one_bit_ok),
		.reached_out(egr_link_ovf)
	);

	irs_sbe_counter #(
		.LIMIT(irs_pkg::ALLOC_SBE_LIMIT)
	) u_egr_alloc_cnt (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.event_in   (events_in.egr_memory_allocation_unit_sbe & one_bit_ok),
		.reached_out(egr_alloc_ovf)
	);

	irs_sbe_counter #(
		.LIMIT(irs_pkg::ALLOC_SBE_LIMIT)
	) u_ing_alloc_cnt (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.event_in   (events_in.ing_memory_allocation_unit_sbe & one_bit_ok),
		.reached_out(ing_alloc_ovf)
	);

	// timeout is off unless the enable input is raised
	irs_credit_timer #(
		.SHORT_CYC(CREDIT_SHORT_CYC),
		.LONG_CYC (CREDIT_LONG_CYC)
	) u_credit_timer (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.enable_in  (credit_timeout_en_in),
		.long_sel_in(credit_timeout_long_in),
		.update_in  (events_in.credit_update),
		.pending_in (events_in.credit_pending),
		.timeout_out(credit_tmo)
	);

	// ----------------------------------------
	// flag sources
	// ----------------------------------------
	always_comb begin
		ev = '0;
		ev[irs_pkg::FLG_CPL_FIFO_OVF] = events_in.ing_cpl_fifo_ovf
			| events_in.egr_cpl_fifo_ovf;
		ev[irs_pkg::FLG_EGR_PKT_SBE_OVF]  = egr_pkt_ovf;
		ev[irs_pkg::FLG_EGR_LINK_SBE_OVF] = egr_link_ovf;
		ev[irs_pkg::FLG_EGR_PKT_DBE]  = events_in.egr_packet_ram_dbe & two_bit_ok;
		ev[irs_pkg::FLG_EGR_LINK_DBE] = events_in.egr_link_list_ram_dbe & two_bit_ok;
		ev[irs_pkg::FLG_ING_PKT_SBE]  = events_in.ing_packet_ram_sbe & one_bit_ok;
		ev[irs_pkg::FLG_EGR_ALLOC_SBE] = egr_alloc_ovf;
		ev[irs_pkg::FLG_EGR_ALLOC_DBE] = events_in.egr_memory_allocation_unit_dbe
			& two_bit_ok;
		ev[irs_pkg::FLG_ING_PKT_DBE]  = events_in.ing_packet_ram_dbe & two_bit_ok;
		ev[irs_pkg::FLG_ING_LINK_SBE] = events_in.ing_link_list_ram_sbe & one_bit_ok;
		ev[irs_pkg::FLG_ING_LINK_DBE] = events_in.ing_link_list_ram_dbe & two_bit_ok;
		ev[irs_pkg::FLG_CREDIT_TIMEOUT]  = credit_tmo;
		ev[irs_pkg::FLG_CREDIT_UNDERRUN] = events_in.ingress_credit_handler_underrun;
		ev[irs_pkg::FLG_ING_ALLOC_SBE] = ing_alloc_ovf;
		ev[irs_pkg::FLG_ING_ALLOC_DBE] = events_in.ing_memory_allocation_unit_dbe
			& two_bit_ok;
	end

	// ----------------------------------------
	// registers and reporting
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		clr    = '0;
		fresh  = '0;

		if (reg_req_in.wr) begin
			if (hit(reg_req_in, irs_pkg::OFS_CHECK_DISABLE)) begin
				st_nxt.check_disable = reg_req_in.wdata[irs_pkg::DIS_W-1:0];
			end
			if (hit(reg_req_in, irs_pkg::OFS_ERROR_FLAGS)) begin
				clr = reg_req_in.wdata[irs_pkg::FLAG_W-1:0];
			end
			if (hit(reg_req_in, irs_pkg::OFS_ERROR_MASKS)) begin
				st_nxt.masks = reg_req_in.wdata[irs_pkg::FLAG_W-1:0];
			end
		end

		// a new event beats a same-cycle clear, so no error is lost
		st_nxt.flags = (st_r.flags & ~clr) | ev;

		// level interrupt for legacy signalling, one-cycle request for messages
		st_nxt.irq = |(st_nxt.flags & ~st_nxt.masks);
		fresh = ev & ~st_r.flags & ~st_nxt.masks;
		st_nxt.msg_req = |fresh;

		st_nxt.one_bit_en = ~st_nxt.check_disable[irs_pkg::DIS_ONE_BIT];
		st_nxt.two_bit_en = ~st_nxt.check_disable[irs_pkg::DIS_TWO_BIT];

		// reads return the value before any write in the same cycle
		st_nxt.rsp.rvalid = reg_req_in.rd;
		st_nxt.rsp.rdata  = '0;
		if (reg_req_in.rd) begin
			if (hit(reg_req_in, irs_pkg::OFS_CHECK_DISABLE)) begin
				st_nxt.rsp.rdata = {{(irs_pkg::DATA_W - irs_pkg::DIS_W){1'b0}},
					st_r.check_disable};
			end else if (hit(reg_req_in, irs_pkg::OFS_ERROR_FLAGS)) begin
				st_nxt.rsp.rdata = widen(st_r.flags);
			end else if (hit(reg_req_in, irs_pkg::OFS_ERROR_MASKS)) begin
				st_nxt.rsp.rdata = widen(st_r.masks);
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_r.check_disable <= irs_pkg::DISABLE_RESET;
			st_r.flags         <= irs_pkg::FLAGS_RESET;
			st_r.masks         <= irs_pkg::MASKS_RESET;
			st_r.rsp           <= '0;
			st_r.one_bit_en    <= 1'b1;
			st_r.two_bit_en    <= 1'b1;
			st_r.irq           <= 1'b0;
			st_r.msg_req       <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rsp_out          = st_r.rsp;
	assign one_bit_check_en_out = st_r.one_bit_en;
	assign two_bit_check_en_out = st_r.two_bit_en;
	assign err_irq_out          = st_r.irq;
	assign err_msg_req_out      = st_r.msg_req;

endmodule

// ===== tb/irs_error_status_properties.sv
/*
 * irs_error_status_properties: port-level checks of irs_error_status.
 * assumes: bound to the design by the testbench; one clock, sync active-high reset.
 */
`timescale 1ns/1ps
module irs_error_status_properties #(
	parameter int CREDIT_SHORT_CYC = irs_pkg::CREDIT_TMO_SHORT_CYC,
	parameter int CREDIT_LONG_CYC  = irs_pkg::CREDIT_TMO_LONG_CYC
) (
	input wire logic                  clock_in,
	input wire logic                  rst_in,
	input wire irs_pkg::irs_reg_req_t reg_req_in,
	input wire irs_pkg::irs_reg_rsp_t reg_rsp_out,
	input wire irs_pkg::irs_events_t  events_in,
	input wire logic                  one_bit_check_en_out,
	input wire logic                  two_bit_check_en_out,
	input wire logic                  err_irq_out,
	input wire logic                  err_msg_req_out
);
	// ----------------------------------------
	// shadow of the writable registers
	// ----------------------------------------
	logic [irs_pkg::FLAG_W-1:0] mask_r;
	logic [irs_pkg::DIS_W-1:0]  dis_r;
	wire wr_c  = reg_req_in.wr;
	wire rd_c  = reg_req_in.rd;
	wire dis_a = reg_req_in.addr == irs_pkg::OFS_CHECK_DISABLE;
	wire flg_a = reg_req_in.addr == irs_pkg::OFS_ERROR_FLAGS;
	wire msk_a = reg_req_in.addr == irs_pkg::OFS_ERROR_MASKS;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mask_r <= irs_pkg::MASKS_RESET;
			dis_r <= irs_pkg::DISABLE_RESET;
		end else if (wr_c) begin
			if (msk_a) begin
				mask_r <= reg_req_in.wdata[14:0];
			end
			if (dis_a) begin
				dis_r <= reg_req_in.wdata[1:0];
			end
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	a_disable_read: assert property (rd_c && dis_a |=> reg_rsp_out.rvalid &&
		reg_rsp_out.rdata == {30'h0, $past(dis_r)}) else $error("disable read wrong");
	a_mask_read: assert property (rd_c && msk_a |=> reg_rsp_out.rvalid &&
		reg_rsp_out.rdata == {17'h0, $past(mask_r)}) else $error("mask read wrong");
	a_flags_reserved: assert property (rd_c && flg_a |=> reg_rsp_out.rvalid &&
		reg_rsp_out.rdata[31:15] == 17'h0) else $error("flag reserved bits set");
	a_check_enables: assert property (wr_c && dis_a |=>
		one_bit_check_en_out == !$past(reg_req_in.wdata[0]) &&
		two_bit_check_en_out == !$past(reg_req_in.wdata[1])) else $error("check enable wrong");
	a_check_hold: assert property (!(wr_c && dis_a) |=>
		$stable(one_bit_check_en_out)) else $error("check enable moved");
	a_masked_quiet: assert property (mask_r == irs_pkg::MASKS_RESET |->
		!err_irq_out) else $error("irq with all masked");
	a_msg_has_irq: assert property (err_msg_req_out |-> err_irq_out)
		else $error("message without irq");
	a_irq_rise_msg: assert property ($rose(err_irq_out) && !$past(wr_c) |->
		err_msg_req_out) else $error("new flag without message");
	a_irq_sticky: assert property (err_irq_out && !wr_c |=> err_irq_out)
		else $error("irq dropped without write");
	a_dbe_direct: assert property (events_in.ing_packet_ram_dbe && !dis_r[1] &&
		!mask_r[8] && !wr_c |=> err_irq_out) else $error("double-bit not reported");
	a_fifo_direct: assert property ((events_in.ing_cpl_fifo_ovf ||
		events_in.egr_cpl_fifo_ovf) && !mask_r[0] && !wr_c |=> err_irq_out)
		else $error("fifo overflow not reported");
endmodule

// ===== tb/testbench.sv
/*
 * testbench: register and event tests of irs_error_status.
 * assumes: credit timeouts shortened to 20 and 40 cycles.
 */
`timescale 1ns/1ps
module testbench;
	localparam logic [11:0] A_DIS = irs_pkg::OFS_CHECK_DISABLE;
	localparam logic [11:0] A_FLG = irs_pkg::OFS_ERROR_FLAGS;
	localparam logic [11:0] A_MSK = irs_pkg::OFS_ERROR_MASKS;
	logic                  clock_in;
	logic                  rst_in;
	irs_pkg::irs_reg_req_t req;
	irs_pkg::irs_reg_rsp_t rsp;
	irs_pkg::irs_events_t  ev;
	logic                  tmo_en;
	logic                  tmo_long;
	logic                  one_en;
	logic                  two_en;
	logic                  irq;
	logic                  msg;
	int                    n_errors = 0;
	int                    n_compared = 0;
	int                    cyc = 0;
	// event bit per flag (struct msb first); -1 marks the timer flag
	int                    evb [15] = '{16, 14, 12, 13, 11, 10, 6, 5, 9, 8, 7, -1, 0, 4, 3};
	int                    cnt [15] = '{1, 256, 256, 1, 1, 1, 8, 1, 1, 1, 1, 0, 1, 8, 1};

	irs_error_status #(.CREDIT_SHORT_CYC(20), .CREDIT_LONG_CYC(40)) irs_error_status_inst (
		.clock_in(clock_in), .rst_in(rst_in), .reg_req_in(req), .reg_rsp_out(rsp),
		.events_in(ev), .credit_timeout_en_in(tmo_en), .credit_timeout_long_in(tmo_long),
		.one_bit_check_en_out(one_en), .two_bit_check_en_out(two_en),
		.err_irq_out(irq), .err_msg_req_out(msg));

	// ----------------------------------------
	// tasks; all start and end at a falling edge
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clock_in);
		req.wr = 1'b0;
		// one idle edge so a following call never re-raises a strobe in the same step
		@(negedge clock_in);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clock_in);
		req.rd = 1'b0;
		chk({name, " valid"}, {31'h0, rsp.rvalid}, 32'h1);
		chk(name, rsp.rdata, exp);
		@(negedge clock_in);
	endtask
	task automatic pulse(input int b, input int n);
		repeat (n) begin
			ev[b] = 1'b1;
			@(negedge clock_in);
		end
		ev[b] = 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock, hang guard and main sequence
	// ----------------------------------------
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			summarize();
		end
	end
	initial begin
		rst_in = 1'b1;
		req = '0;
		ev = '0;
		tmo_en = 1'b0;
		tmo_long = 1'b0;
		idle(6);
		rst_in = 1'b0;
		idle(1);
		rd(A_DIS, 32'h0, "disable");
		rd(A_FLG, 32'h0, "flags");
		rd(A_MSK, 32'h7fff, "masks");
		rd(12'h1d4, 32'h0, "unmapped");
		chk("check enables", {30'h0, one_en, two_en}, 32'h3);
		$display("test reset values done");
		wr(A_DIS, 32'hffffffff);
		rd(A_DIS, 32'h3, "disable");
		chk("check enables", {30'h0, one_en, two_en}, 32'h0);
		wr(A_DIS, 32'h1);
		chk("check enables", {30'h0, one_en, two_en}, 32'h1);
		wr(A_DIS, 32'h0);
		$display("test check disable done");
		// counters get every event but the last back to back, then a quiet gap
		wr(A_MSK, 32'h0);
		for (int f = 0; f < 15; f++) begin
			if (evb[f] >= 0) begin
				pulse(evb[f], cnt[f] - 1);
				idle(2);
				rd(A_FLG, 32'h0, "flag early");
				pulse(evb[f], 1);
				chk("msg pulse", {31'h0, msg}, {31'h0, cnt[f] == 1});
				idle(1);
				rd(A_FLG, 32'h1 << f, "flag set");
				chk("irq", {31'h0, irq}, 32'h1);
				wr(A_FLG, ~(32'h1 << f));
				rd(A_FLG, 32'h1 << f, "flag sticky");
				wr(A_FLG, 32'h1 << f);
				rd(A_FLG, 32'h0, "flag cleared");
				chk("irq", {31'h0, irq}, 32'h0);
			end
		end
		pulse(15, 1);
		idle(1);
		rd(A_FLG, 32'h1, "egress fifo");
		wr(A_FLG, 32'h1);
		$display("test flags done");
		wr(A_MSK, 32'hffffffff);
		pulse(9, 1);
		idle(1);
		rd(A_FLG, 32'h100, "masked flag");
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(A_MSK, 32'hffff7eff);
		rd(A_MSK, 32'h7eff, "masks");
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		wr(A_FLG, 32'h100);
		wr(A_MSK, 32'h7fff);
		$display("test masks done");
		wr(A_DIS, 32'h1);
		pulse(10, 1);
		pulse(9, 1);
		idle(1);
		rd(A_FLG, 32'h100, "one-bit refused");
		wr(A_FLG, 32'h7fff);
		wr(A_DIS, 32'h2);
		pulse(10, 1);
		pulse(9, 1);
		idle(1);
		rd(A_FLG, 32'h20, "two-bit refused");
		wr(A_FLG, 32'h7fff);
		wr(A_DIS, 32'h0);
		$display("test refusal done");
		ev.credit_pending = 1'b1;
		idle(60);
		rd(A_FLG, 32'h0, "timeout off");
		tmo_en = 1'b1;
		idle(12);
		rd(A_FLG, 32'h0, "short early");
		idle(15);
		rd(A_FLG, 32'h800, "short timeout");
		tmo_en = 1'b0;
		wr(A_FLG, 32'h800);
		tmo_long = 1'b1;
		tmo_en = 1'b1;
		idle(30);
		rd(A_FLG, 32'h0, "long early");
		idle(15);
		rd(A_FLG, 32'h800, "long timeout");
		tmo_en = 1'b0;
		ev.credit_pending = 1'b0;
		$display("test credit timeout done");
		summarize();
	end
endmodule

bind irs_error_status irs_error_status_properties #(
	.CREDIT_SHORT_CYC(CREDIT_SHORT_CYC),
	.CREDIT_LONG_CYC(CREDIT_LONG_CYC)
) irs_error_status_properties_inst (
	.clock_in(clock_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
	.reg_rsp_out(reg_rsp_out), .events_in(events_in),
	.one_bit_check_en_out(one_bit_check_en_out),
	.two_bit_check_en_out(two_bit_check_en_out),
	.err_irq_out(err_irq_out), .err_msg_req_out(err_msg_req_out));
